// ==== include/usic_pkg.sv ====
// package: register map, field layout and event carriers for the status block
package usic_pkg;
    localparam int ADDR_W = 12;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_STATUS = 10'h0BA;
    localparam logic [9:0] IDX_FLAGS = 10'h098;
    localparam logic [9:0] IDX_TXBUF = 10'h099;
    // status register fields
    localparam int B_STAT_EN = 0;
    localparam int B_OVR = 1;
    localparam int B_BRK = 2;
    localparam int B_FRAME_ERR = 3;
    localparam int B_DBSEL = 4;
    localparam int B_SPLIT = 5;
    localparam int B_POS = 6;
    localparam int B_DBUF_EN = 7;
    // flags register fields; B_TXFULL is bit 15 of the transmit buffer register
    localparam int B_RXDONE = 0;
    localparam int B_TXDONE = 1;
    localparam int B_BRKRST = 6;
    localparam int B_TXFULL = 15;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam int BREAK_BITS = 11;
    localparam int CNT_W = 4;

    typedef struct packed {
        logic sample_valid;
        logic sample_level;
        logic bit8_seen;
        logic frame_end;
        logic stop_level;
        logic char_done;
    } usic_rx_ev_s;

    typedef struct packed {
        logic busy;
        logic stop_begin;
        logic stop_end;
    } usic_tx_ev_s;

    typedef struct packed {
        logic start;
        logic [8:0] data;
    } usic_tx_cmd_s;
endpackage : usic_pkg

// ==== src/usic_status.sv ====
// status, error flags, interrupt routing and transmit double buffer
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module usic_status
    import usic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire usic_rx_ev_s rx_ev,
    input wire usic_tx_ev_s tx_ev,
    output usic_tx_cmd_s tx_cmd,
    output logic rx_hold_idle,
    output logic rx_done_flag,
    output logic irq_rx_req,
    output logic irq_tx_req,
    output logic break_reset
);
    logic status_irq_enable;
    logic overrun_flag;
    logic line_break_flag;
    logic framing_error_flag;
    logic dbuf_tx_irq_select;
    logic split_irq_select;
    logic tx_irq_position;
    logic dbuf_mode_enable;
    logic tx_done_flag;
    logic break_reset_enable;
    logic [CNT_W-1:0] low_count;
    logic [8:0] serial_buffer;
    logic buf_full;
    logic wr_en;
    logic rd_setup;
    logic hit_status;
    logic hit_flags;
    logic hit_txbuf;
    logic mapped;
    logic wr_status;
    logic wr_flags;
    logic wr_txbuf;
    logic break_seen;
    logic ovr_set;
    logic fe_set;
    logic tx_pos_event;
    logic load_now;
    logic load_later;
    logic shifter_busy;
    logic tx_done_set;
    logic err_req;
    logic [7:0] status_rd;
    logic [31:0] next_prdata;

    assign hit_status = paddr[ADDR_W-1:2] == IDX_STATUS;
    assign hit_flags = paddr[ADDR_W-1:2] == IDX_FLAGS;
    assign hit_txbuf = paddr[ADDR_W-1:2] == IDX_TXBUF;
    assign mapped = hit_status | hit_flags | hit_txbuf;
    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_en = psel & penable & pwrite & pready;
    assign wr_status = wr_en & hit_status;
    assign wr_flags = wr_en & hit_flags;
    assign wr_txbuf = wr_en & hit_txbuf;

    assign status_rd = {dbuf_mode_enable, tx_irq_position, split_irq_select,
        dbuf_tx_irq_select, framing_error_flag, line_break_flag,
        overrun_flag, status_irq_enable};

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (hit_status)
            next_prdata[7:0] = status_rd;
        else if (hit_flags)
        begin
            next_prdata[B_RXDONE] = rx_done_flag;
            next_prdata[B_TXDONE] = tx_done_flag;
            next_prdata[B_BRKRST] = break_reset_enable;
        end
        else if (hit_txbuf)
        begin
            next_prdata[8:0] = serial_buffer;
            next_prdata[B_TXFULL] = buf_full;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= next_prdata;
    end

    // control bits of the status register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_irq_enable <= STATUS_RST[B_STAT_EN];
            dbuf_tx_irq_select <= STATUS_RST[B_DBSEL];
            split_irq_select <= STATUS_RST[B_SPLIT];
            tx_irq_position <= STATUS_RST[B_POS];
            dbuf_mode_enable <= STATUS_RST[B_DBUF_EN];
        end
        else if (wr_status)
        begin
            status_irq_enable <= pwdata[B_STAT_EN];
            dbuf_tx_irq_select <= pwdata[B_DBSEL];
            split_irq_select <= pwdata[B_SPLIT];
            tx_irq_position <= pwdata[B_POS];
            dbuf_mode_enable <= pwdata[B_DBUF_EN];
        end
    end

    // break detection on per-bit samples from the receiver
    assign break_seen = rx_ev.sample_valid & ~rx_ev.sample_level &
        (low_count == CNT_W'(BREAK_BITS - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_count <= '0;
        else if (rx_ev.sample_valid)
        begin
            if (rx_ev.sample_level)
                low_count <= '0;
            // parks one past the trigger: a long low run breaks once
            else if (low_count != CNT_W'(BREAK_BITS))
                low_count <= low_count + 1'b1;
        end
    end

    // receiver held idle after a break until a high (stop) sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_hold_idle <= 1'b0;
        else if (break_seen)
            rx_hold_idle <= 1'b1;
        else if (rx_ev.sample_valid & rx_ev.sample_level)
            rx_hold_idle <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            break_reset <= 1'b0;
        else
            break_reset <= break_seen & break_reset_enable;
    end

    assign ovr_set = rx_ev.bit8_seen & rx_done_flag;
    assign fe_set = (rx_ev.frame_end & ~rx_ev.stop_level) | break_seen;

    // error flags: only software clears, by writing 0; set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            overrun_flag <= 1'b0;
        else if (ovr_set)
            overrun_flag <= 1'b1;
        else if (wr_status & ~pwdata[B_OVR])
            overrun_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_break_flag <= 1'b0;
        else if (break_seen)
            line_break_flag <= 1'b1;
        else if (wr_status & ~pwdata[B_BRK])
            line_break_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            framing_error_flag <= 1'b0;
        else if (fe_set)
            framing_error_flag <= 1'b1;
        else if (wr_status & ~pwdata[B_FRAME_ERR])
            framing_error_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            break_reset_enable <= 1'b0;
        else if (wr_flags)
            break_reset_enable <= pwdata[B_BRKRST];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_done_flag <= 1'b0;
        else if (rx_ev.char_done)
            rx_done_flag <= 1'b1;
        else if (wr_flags & ~pwdata[B_RXDONE])
            rx_done_flag <= 1'b0;
    end

    // transmit path: one holding buffer in front of the shifter
    assign tx_pos_event = tx_irq_position ? tx_ev.stop_end
                                          : tx_ev.stop_begin;
    // a start the shifter has not seen yet still counts as busy
    assign shifter_busy = tx_ev.busy | tx_cmd.start;
    // idle shifter: load at once, whatever the mode
    assign load_now = wr_txbuf & ~buf_full & ~shifter_busy;
    // pending char follows the current one after its stop bit
    assign load_later = buf_full & tx_ev.stop_end;

    always_comb
    begin
        if (dbuf_mode_enable)
        begin
            // irq per write: at once when empty, else at the position; dbuf_tx_irq_select adds one at the position once empty
            tx_done_set = load_now | (tx_pos_event & buf_full);
            if (tx_pos_event & ~buf_full & dbuf_tx_irq_select)
                tx_done_set = 1'b1;
        end
        else
        begin
            // one irq per character at the position; may leave a gap
            tx_done_set = tx_pos_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_done_flag <= 1'b0;
        else if (tx_done_set)
            tx_done_flag <= 1'b1;
        else if (wr_flags & ~pwdata[B_TXDONE])
            tx_done_flag <= 1'b0;
    end

    // a write while the buffer is full is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_buffer <= 9'h000;
            buf_full <= 1'b0;
        end
        else if (wr_txbuf & ~buf_full & shifter_busy)
        begin
            serial_buffer <= pwdata[8:0];
            buf_full <= 1'b1;
        end
        else if (load_later)
            buf_full <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_cmd <= '0;
        else if (load_now)
        begin
            tx_cmd.start <= 1'b1;
            tx_cmd.data <= pwdata[8:0];
        end
        else if (load_later)
        begin
            tx_cmd.start <= 1'b1;
            tx_cmd.data <= serial_buffer;
        end
        else
            tx_cmd.start <= 1'b0;
    end

    // interrupt routing
    assign err_req = status_irq_enable &
        (framing_error_flag | line_break_flag | overrun_flag);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_rx_req <= 1'b0;
            irq_tx_req <= 1'b0;
        end
        else if (split_irq_select)
        begin
            irq_rx_req <= rx_done_flag | err_req;
            irq_tx_req <= tx_done_flag;
        end
        else
        begin
            // combined vector rides on the receive line
            irq_rx_req <= rx_done_flag | tx_done_flag | err_req;
            irq_tx_req <= 1'b0;
        end
    end
endmodule : usic_status

// ==== verification/usic_remote.sv ====
// remote line partner: receive events and transmit shifter timing
`timescale 1ns/10ps
module usic_remote
    import usic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire usic_tx_cmd_s tx_cmd,
    output usic_rx_ev_s rx_ev,
    output usic_tx_ev_s tx_ev
);
    logic [3:0] tcnt;
    // line idles high, so the level bits rest at 1
    initial rx_ev = 6'h12;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tcnt <= 4'h0;
        else if (tx_cmd.start)
            tcnt <= 4'h8;
        else if (tcnt != 4'h0)
            tcnt <= tcnt - 4'h1;
    end
    assign tx_ev.busy = tcnt != 4'h0;
    assign tx_ev.stop_begin = tcnt == 4'h2;
    assign tx_ev.stop_end = tcnt == 4'h1;
    task automatic rx_frame(input logic stop);
        @(posedge pclk) rx_ev <= 6'h1A;
        @(posedge pclk) rx_ev <= {4'h5, stop, 1'b1};
        @(posedge pclk) rx_ev <= 6'h12;
    endtask : rx_frame
    task automatic rx_break(input int lows);
        repeat (lows) @(posedge pclk) rx_ev <= 6'h22;
        @(posedge pclk) rx_ev <= 6'h32;
        @(posedge pclk) rx_ev <= 6'h12;
    endtask : rx_break
endmodule : usic_remote

// ==== verification/usic_status_bench.sv ====
// self-checking bench: apb register tasks and line scenarios
`timescale 1ns/10ps
module usic_status_bench import usic_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, err, rx_hold_idle, rx_done_flag;
    logic irq_rx_req, irq_tx_req, break_reset;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    usic_rx_ev_s rx_ev;
    usic_tx_ev_s tx_ev;
    usic_tx_cmd_s tx_cmd;
    int num_errors = 0, total_checks = 0, brk_cnt = 0, starts = 0;
    always #12.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        brk_cnt += int'(break_reset);
        starts += int'(tx_cmd.start);
    end
    usic_status i_usic_status (.*);
    usic_remote i_usic_remote (.*);
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic tmo(input int n, lim);
        if (n >= lim)
        begin
            num_errors++;
            test_done();
        end
    endtask : tmo
    task automatic apb(input logic [9:0] idx, input logic w,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        tmo(n, 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp,
        input string nm);
        apb(idx, 1'b0, 32'h0);
        chk(nm, exp, q);
    endtask : rd
    initial
    begin
        int k, n, s0;
        logic [31:0] st;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_STATUS, 32'(STATUS_RST), "status reset");
        rd(10'h3FF, 32'h0, "unmapped data");
        chk("unmapped err", 32'h1, 32'(err));
        i_usic_remote.rx_frame(1'b0);
        rd(IDX_STATUS, 32'h08, "framing");
        chk("rx irq", 32'h1, 32'(irq_rx_req));
        chk("rx done", 32'h1, 32'(rx_done_flag));
        i_usic_remote.rx_frame(1'b1);
        rd(IDX_STATUS, 32'h0A, "overrun");
        apb(IDX_STATUS, 1'b1, 32'h08);
        rd(IDX_STATUS, 32'h08, "clear one");
        apb(IDX_FLAGS, 1'b1, 32'h0);
        for (k = 0; k < 2; k++)
        begin
            apb(IDX_STATUS, 1'b1, 32'h08 | 32'(k));
            repeat (2) @(posedge pclk);
            chk("status irq", 32'(k), 32'(irq_rx_req));
            chk("tx irq combined", 32'h0, 32'(irq_tx_req));
        end
        apb(IDX_STATUS, 1'b1, 32'h0);
        apb(IDX_FLAGS, 1'b1, 32'h40);
        i_usic_remote.rx_break(BREAK_BITS - 1);
        rd(IDX_STATUS, 32'h0, "short break");
        i_usic_remote.rx_break(BREAK_BITS);
        rd(IDX_STATUS, 32'h0C, "break");
        chk("break reset", 32'h1, 32'(brk_cnt));
        chk("idle hold", 32'h0, 32'(rx_hold_idle));
        apb(IDX_STATUS, 1'b1, 32'h0);
        for (k = 0; k < 3; k++)
        begin
            s0 = starts;
            st = (k == 2) ? 32'h20 : 32'hA0 | 32'(k * 'h50);
            apb(IDX_STATUS, 1'b1, st);
            apb(IDX_FLAGS, 1'b1, 32'h0);
            apb(IDX_TXBUF, 1'b1, 32'h1A5);
            repeat (2) @(posedge pclk);
            chk("tx irq at once", 32'(k < 2), 32'(irq_tx_req));
            apb(IDX_TXBUF, 1'b1, 32'h05A);
            rd(IDX_TXBUF, 32'h805A, "buffer full");
            for (n = 0; n < 40 && starts < s0 + 2; n++) @(posedge pclk);
            tmo(n, 40);
            chk("tx data", 32'h05A, 32'(tx_cmd.data));
            apb(IDX_FLAGS, 1'b1, 32'h0);
            for (n = 0; n < 40 && tx_ev.busy !== 1'b0; n++) @(posedge pclk);
            tmo(n, 40);
            st = 32'(k != 0);
            rd(IDX_FLAGS, st << B_TXDONE, "last tx irq");
            chk("tx irq split", st, 32'(irq_tx_req));
            chk("starts", 32'(s0 + 2), 32'(starts));
        end
        test_done();
    end
endmodule : usic_status_bench

// ==== verification/usic_status_monitor.sv ====
// port-level assertions for the status and interrupt block
`timescale 1ns/10ps
module usic_status_monitor
    import usic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire usic_rx_ev_s rx_ev,
    input wire usic_tx_ev_s tx_ev,
    input wire usic_tx_cmd_s tx_cmd,
    input wire logic rx_hold_idle,
    input wire logic rx_done_flag,
    input wire logic irq_rx_req,
    input wire logic irq_tx_req,
    input wire logic break_reset
);
    default clocking mon_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    rx_irq_a: assert property (rx_done_flag |=> irq_rx_req)
        else $error("receive irq missing");
    rx_done_cause_a: assert property ($rose(rx_done_flag) |->
        $past(rx_ev.char_done)) else $error("receive done uncaused");
    brk_pulse_a: assert property (break_reset |=> !break_reset)
        else $error("break reset too long");
    brk_idle_a: assert property (break_reset |-> ##[0:1] rx_hold_idle)
        else $error("break without idle hold");
    hold_cause_a: assert property ($rose(rx_hold_idle) |->
        $past(rx_ev.sample_valid && !rx_ev.sample_level) ||
        $past(rx_ev.sample_valid && !rx_ev.sample_level, 2))
        else $error("idle hold without low sample");
    hold_release_a: assert property (rx_ev.sample_valid &&
        rx_ev.sample_level |-> ##[1:2] !rx_hold_idle)
        else $error("idle hold not released");
    start_cause_a: assert property (tx_cmd.start |->
        $past(psel && penable && pwrite && paddr[11:2] == IDX_TXBUF)
        || $past(tx_ev.stop_end)) else $error("unexpected tx start");
    start_pulse_a: assert property (tx_cmd.start |=> !tx_cmd.start)
        else $error("tx start too long");
    cover property (break_reset);
    cover property (tx_cmd.start && $past(tx_ev.stop_end));
    cover property (irq_tx_req);
    cover property (pslverr);
endmodule : usic_status_monitor

bind usic_status usic_status_monitor i_usic_status_monitor (.*);
